// ===== css_core_state.sv
// Core state logic of a small 8-bit controller: stack, data map, flags, tables.
// Assumes decode raises one-cycle operation strobes and that a program word
// arrives on rom_word in the same cycle as tbl_rom_rd.
//
// Local design decisions: strobed register access and the placing of the registers.
`include "css_regs.svh"

// Notes on behaviour
// - Table address: PC page or all-ones page
// - Table instructions take two cycles
// - Six-level PC-only stack, hidden from software
// - Call or interrupt acknowledge pushes PC
// - Return pops stack into PC
// - Reset points stack pointer at top
// - Full stack holds interrupt until pop
// - Call on full stack drops oldest
// - Reserved data addresses read zero
// - General memory range per variant
// - Address zero redirects through pointer
// - Pointer at zero: read zero, no write
// - Pointer width per variant, small part's bit7 reads one
// - Software cannot change sleep or watchdog flags
// - Watchdog flag: set timeout, clear kick/sleep
// - Sleep flag: set sleep, clear kick
// - Carry from add, no-borrow, rotates
// - Half carry from low nibble
// - Zero flag on zero result
// - Overflow: carry into and out differ
// - Flag bits 6 and 7 read zero
// - Flags are never stacked
module css_core_state #(
  parameter bit LARGE = 1'b1  // 1: 12-bit program, 8-bit pointer
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              arst_n,
  // Register bus
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // Control flow from decode
  input  wire logic [11:0]       pc_now,
  input  wire logic              op_call,
  input  wire logic              op_subroutine_exit,
  input  wire logic              op_interrupt_exit,
  input  wire logic              int_pending,
  output logic                   int_ack,
  output logic [11:0]            pc_restore,
  output logic                   pc_restore_valid,
  output logic                   stack_full,
  // Table reads
  input  wire logic              op_table_read_current_page,
  input  wire logic              op_table_read_last_page,
  input  wire logic [7:0]        tbl_dest,
  input  wire logic [14:0]       rom_word,
  output logic [11:0]            tbl_addr,
  output logic                   tbl_rom_rd,
  output logic                   tbl_busy,
  // ALU
  input  wire logic              alu_go,
  input  wire css_pkg::css_alu_op_t alu_op,
  input  wire logic [7:0]        alu_a,
  input  wire logic [7:0]        alu_b,
  input  wire logic              alu_cin,
  output logic      [7:0]        alu_result,
  // Power and watchdog events
  input  wire logic              op_watchdog_kick,
  input  wire logic              op_sleep,
  input  wire logic              wdt_timeout,
  output logic      [7:0]        alu_flag_register
);
  import css_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [11:0]    stack_mem [0:5];   // Return addresses only, no bus path
  logic [2:0]     stack_wr;          // Next slot to write
  logic [2:0]     stack_cnt;         // Entries held, 0..6
  logic [7:0]     indirect_pointer;  // Stored pointer bits
  logic [7:0]     tbl_ptr;           // Table pointer register
  logic [7:0]     table_high_latch;  // Upper table bits
  logic [7:0]     data_mem [0:255];  // Only the general range is used
  css_tbl_state_t tbl_state;
  logic [7:0]     tbl_dst_q;         // Destination held over the fetch

  // --------------------------------------------------------------------------
  // Data map helpers
  // --------------------------------------------------------------------------
  // Pointer as software sees it; small part keeps seven bits
  logic [7:0] ptr_view;
  assign ptr_view = LARGE ? indirect_pointer : {1'b1, indirect_pointer[6:0]};

  // True for the general-purpose range of this variant
  function automatic logic is_gp(input logic [7:0] a);
    if (LARGE) begin
      is_gp = (a >= `CSS_GP_LO_LARGE) && (a <= `CSS_GP_HI_LARGE);
    end else begin
      is_gp = (a >= `CSS_GP_LO_SMALL) && (a <= `CSS_GP_HI_SMALL);
    end
  endfunction : is_gp

  // Address zero stands for the location named by the pointer
  function automatic logic [7:0] eff_addr(input logic [7:0] a, input logic [7:0] p);
    eff_addr = (a == `CSS_ADDR_INDIRECT) ? p : a;
  endfunction : eff_addr

  logic [7:0] bus_eff;
  logic [7:0] tbl_eff;
  assign bus_eff = eff_addr(reg_addr, ptr_view);
  assign tbl_eff = eff_addr(tbl_dst_q, ptr_view);

  // --------------------------------------------------------------------------
  // Stack
  // --------------------------------------------------------------------------
  logic       do_pop;
  logic       do_int;
  logic       do_push;
  logic [2:0] rd_slot;
  assign do_pop  = op_subroutine_exit | op_interrupt_exit;
  // A pop frees a slot, so service waits for it rather than racing it
  assign do_int  = int_pending & (stack_cnt != `CSS_STACK_DEPTH) & ~do_pop
                   & ~op_call;
  assign do_push = op_call | do_int;
  assign rd_slot = (stack_wr == 3'h0) ? 3'h5 : stack_wr - 3'h1;

  // Pointer and fill count; reset leaves the stack empty at its top
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stack_wr  <= 3'h0;
      stack_cnt <= 3'h0;
    end else if (do_push) begin
      stack_wr <= (stack_wr == 3'h5) ? 3'h0 : stack_wr + 3'h1;
      if (stack_cnt != `CSS_STACK_DEPTH) begin
        stack_cnt <= stack_cnt + 3'h1;
      end
      // Full: count saturates and the oldest slot is overwritten
    end else if (do_pop) begin
      stack_wr <= rd_slot;
      if (stack_cnt != 3'h0) begin
        stack_cnt <= stack_cnt - 3'h1;
      end
    end
  end

  // Slot storage; only the program counter goes in, never the flags
  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      stack_mem[stack_wr] <= pc_now;
    end
  end

  // Popped address, acknowledge and full indication
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pc_restore       <= 12'h000;
      pc_restore_valid <= 1'b0;
      int_ack          <= 1'b0;
      stack_full       <= 1'b0;
    end else begin
      pc_restore_valid <= do_pop & ~do_push;
      if (do_pop & ~do_push) begin
        pc_restore <= stack_mem[rd_slot];
      end
      int_ack    <= do_int;
      stack_full <= do_push ? (stack_cnt >= 3'h5)
                  : do_pop ? 1'b0 : (stack_cnt == `CSS_STACK_DEPTH);
    end
  end

  // --------------------------------------------------------------------------
  // Table read sequence
  // --------------------------------------------------------------------------
  logic tbl_start;
  assign tbl_start = (tbl_state == CSS_TB_IDLE) &
                     (op_table_read_current_page | op_table_read_last_page);

  // Fetch cycle then store cycle: two cycles per table instruction
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tbl_state  <= CSS_TB_IDLE;
      tbl_addr   <= 12'h000;
      tbl_rom_rd <= 1'b0;
      tbl_busy   <= 1'b0;
      tbl_dst_q  <= 8'h00;
    end else begin
      tbl_rom_rd <= tbl_start;
      case (tbl_state)
        CSS_TB_IDLE: begin
          if (tbl_start) begin
            tbl_state <= CSS_TB_FETCH;
            tbl_busy  <= 1'b1;
            tbl_dst_q <= tbl_dest;
            // Current page keeps PC upper bits; last page forces ones
            if (op_table_read_last_page) begin
              tbl_addr <= {`CSS_LAST_PAGE, tbl_ptr};
            end else begin
              tbl_addr <= {pc_now[11:8], tbl_ptr};
            end
            if (!LARGE) begin
              tbl_addr[11] <= 1'b0; // Small part: 11-bit table space
            end
          end
        end
        CSS_TB_FETCH: begin
          tbl_state <= CSS_TB_STORE;
        end
        CSS_TB_STORE: begin
          tbl_state <= CSS_TB_IDLE;
          tbl_busy  <= 1'b0;
        end
        default: begin
          tbl_state <= CSS_TB_IDLE;
          tbl_busy  <= 1'b0;
        end
      endcase
    end
  end

  // Upper word bits land low in the latch; unused bits read zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      table_high_latch <= 8'h00;
    end else if (tbl_state == CSS_TB_FETCH) begin
      table_high_latch <= LARGE ? {1'b0, rom_word[14:8]} : {2'b00, rom_word[13:8]};
    end
  end

  // --------------------------------------------------------------------------
  // Data memory and software registers
  // --------------------------------------------------------------------------
  logic tbl_wr;
  logic bus_wr_ok;
  assign tbl_wr    = (tbl_state == CSS_TB_FETCH);
  // Indirect access with the pointer at zero does nothing
  assign bus_wr_ok = reg_wr & ~tbl_wr & (bus_eff != `CSS_ADDR_INDIRECT);

  // General memory; a table store takes the port over a bus write
  always_ff @(posedge clk_sys) begin
    if (tbl_wr && tbl_eff != `CSS_ADDR_INDIRECT && is_gp(tbl_eff)) begin
      data_mem[tbl_eff] <= rom_word[7:0];
    end else if (bus_wr_ok && is_gp(bus_eff)) begin
      data_mem[bus_eff] <= reg_wdata;
    end
  end

  // Pointer and table pointer registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      indirect_pointer <= `CSS_PTR_RESET;
      tbl_ptr          <= 8'h00;
    end else if (bus_wr_ok) begin
      if (bus_eff == `CSS_ADDR_POINTER) begin
        indirect_pointer <= LARGE ? reg_wdata : {1'b0, reg_wdata[6:0]};
      end
      if (bus_eff == `CSS_ADDR_TBL_PTR) begin
        tbl_ptr <= reg_wdata;
      end
    end
  end

  // Read data, one cycle after the strobe; anything unmapped reads zero
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (bus_eff == `CSS_ADDR_INDIRECT) begin
        reg_rdata <= 8'h00;
      end else if (is_gp(bus_eff)) begin
        reg_rdata <= data_mem[bus_eff];
      end else if (bus_eff == `CSS_ADDR_POINTER) begin
        reg_rdata <= ptr_view;
      end else if (bus_eff == `CSS_ADDR_TBL_PTR) begin
        reg_rdata <= tbl_ptr;
      end else if (bus_eff == `CSS_ADDR_TBL_HIGH) begin
        reg_rdata <= table_high_latch;
      end else if (bus_eff == `CSS_ADDR_FLAGS) begin
        reg_rdata <= alu_flag_register;
      end else begin
        reg_rdata <= 8'h00;
      end
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // ALU and flags
  // --------------------------------------------------------------------------
  logic [7:0] b_eff;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [7:0] low8;
  logic [7:0] res;
  logic       is_arith;
  logic       is_rot;
  logic       c_new;
  assign is_arith = (alu_op == CSS_ALU_ADD) | (alu_op == CSS_ALU_SUB);
  assign is_rot   = (alu_op == CSS_ALU_RLC) | (alu_op == CSS_ALU_RRC);
  // Subtract adds the complement; carry-in of one means no borrow in
  assign b_eff    = (alu_op == CSS_ALU_SUB) ? ~alu_b : alu_b;
  assign sum9     = {1'b0, alu_a} + {1'b0, b_eff} + {8'h00, alu_cin};
  assign nib5     = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_cin};
  assign low8     = {1'b0, alu_a[6:0]} + {1'b0, b_eff[6:0]} + {7'h00, alu_cin};

  // Result and rotate carry
  always_comb begin
    c_new = sum9[8];
    case (alu_op)
      CSS_ALU_ADD: res = sum9[7:0];
      CSS_ALU_SUB: res = sum9[7:0];
      CSS_ALU_AND: res = alu_a & alu_b;
      CSS_ALU_OR:  res = alu_a | alu_b;
      CSS_ALU_XOR: res = alu_a ^ alu_b;
      CSS_ALU_RLC: begin
        res   = {alu_a[6:0], alu_flag_register[`CSS_FLAG_C]};
        c_new = alu_a[7];
      end
      CSS_ALU_RRC: begin
        res   = {alu_flag_register[`CSS_FLAG_C], alu_a[7:1]};
        c_new = alu_a[0];
      end
      default: res = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alu_result <= 8'h00;
    end else if (alu_go) begin
      alu_result <= res;
    end
  end

  logic flags_sw_wr;
  assign flags_sw_wr = bus_wr_ok & (bus_eff == `CSS_ADDR_FLAGS);

  // Arithmetic flags: ALU update wins over a same-cycle software write
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alu_flag_register[3:0] <= 4'(`CSS_FLAGS_RESET);
    end else if (alu_go) begin
      if (is_arith) begin
        alu_flag_register[`CSS_FLAG_C]  <= sum9[8];
        alu_flag_register[`CSS_FLAG_AC] <= nib5[4];
        alu_flag_register[`CSS_FLAG_OV] <= low8[7] ^ sum9[8];
      end
      if (is_rot) begin
        alu_flag_register[`CSS_FLAG_C] <= c_new;
      end else begin
        alu_flag_register[`CSS_FLAG_Z] <= (res == 8'h00);
      end
    end else if (flags_sw_wr) begin
      alu_flag_register[3:0] <= reg_wdata[3:0];
    end
  end

  // Sleep and watchdog flags; software writes never reach them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      alu_flag_register[`CSS_FLAG_SLEEP] <= 1'b0;
      alu_flag_register[`CSS_FLAG_WDOG]  <= 1'b0;
    end else begin
      if (op_sleep) begin
        alu_flag_register[`CSS_FLAG_SLEEP] <= 1'b1;
      end else if (op_watchdog_kick) begin
        alu_flag_register[`CSS_FLAG_SLEEP] <= 1'b0;
      end
      // A time-out in the clearing cycle is kept
      if (wdt_timeout) begin
        alu_flag_register[`CSS_FLAG_WDOG] <= 1'b1;
      end else if (op_watchdog_kick || op_sleep) begin
        alu_flag_register[`CSS_FLAG_WDOG] <= 1'b0;
      end
    end
  end

  // Unused bits tied low
  assign alu_flag_register[7:6] = 2'b00;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_FULL_HOLDS_INT: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (stack_cnt == `CSS_STACK_DEPTH && !do_pop) |=> !int_ack)
    else $error("interrupt acknowledged on full stack");

  AST_PUSH_POP_PC: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (op_call && !do_pop) ##1 (op_subroutine_exit && !op_call && !int_pending)
    |=> pc_restore_valid && pc_restore == $past(pc_now, 2))
    else $error("popped address differs from pushed");

  AST_CNT_MAX: assert property (@(posedge clk_sys) disable iff (!arst_n)
    stack_cnt <= `CSS_STACK_DEPTH && stack_wr <= 3'h5)
    else $error("stack count or pointer out of range");

  AST_TBL_TWO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tbl_start |=> tbl_busy [*2] ##1 !tbl_busy)
    else $error("table read not two cycles");

  AST_TBL_LAST: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (tbl_start && op_table_read_last_page && LARGE)
    |=> tbl_addr == {4'hf, $past(tbl_ptr)})
    else $error("last page table address wrong");

  AST_IND_ZERO: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (reg_rd && reg_addr == 8'h00 && ptr_view == 8'h00) |=> reg_rdata == 8'h00)
    else $error("indirect read through zero not zero");

  AST_SW_KEEP: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (flags_sw_wr && !op_sleep && !op_watchdog_kick && !wdt_timeout)
    |=> $stable(alu_flag_register[5:4]))
    else $error("software write changed sleep or watchdog flag");

  AST_WDOG_SET: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wdt_timeout |=> alu_flag_register[`CSS_FLAG_WDOG])
    else $error("time-out did not set watchdog flag");

  AST_ZERO_FLAG: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (alu_go && !is_rot) |=> alu_flag_register[`CSS_FLAG_Z] == (alu_result == 8'h00))
    else $error("zero flag disagrees with result");

  AST_OV_ADD: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (alu_go && alu_op == CSS_ALU_ADD && !alu_cin && alu_a[7] == alu_b[7])
    |=> alu_flag_register[`CSS_FLAG_OV] == (alu_result[7] != $past(alu_a[7])))
    else $error("overflow flag wrong on add");

endmodule : css_core_state

// ===== css_core_state_tb.sv
// Self-checking bench for the core state block: data map, flags, ALU, tables, stack.
// Checks the large variant, and the small one on pointer and reserved reads; one-cycle read data and one-cycle operation strobes.
`include "css_regs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end

module css_core_state_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import css_pkg::*;
  // ----------------------------------------------------------------------
  // Ports, model state and counters
  // ----------------------------------------------------------------------
  logic        clk_sys, arst_n, reg_wr, reg_rd, int_pending, int_ack, alu_go, alu_cin;
  logic        op_call, op_subroutine_exit, op_interrupt_exit, pc_restore_valid, stack_full;
  logic        op_table_read_current_page, op_table_read_last_page, tbl_rom_rd, tbl_busy;
  logic        op_watchdog_kick, op_sleep, wdt_timeout;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, tbl_dest, alu_a, alu_b, alu_result;
  logic [7:0]  alu_flag_register, rv, mf, p, d, r, b2;
  logic [7:0]  rdata_s;          // Read data of the small variant
  logic [11:0] pc_now, pc_restore, tbl_addr, e12;
  logic [14:0] rom_word, rw;
  logic [8:0]  s;
  css_alu_op_t alu_op;
  logic [11:0] q[$];            // Return addresses, newest at the back
  int          i, h, cyc = 0, err_count = 0, compares = 0;

  css_core_state #(.LARGE(1'b1)) dut (
    .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pc_now,
    .op_call, .op_subroutine_exit, .op_interrupt_exit, .int_pending, .int_ack, .pc_restore,
    .pc_restore_valid, .stack_full, .op_table_read_current_page, .op_table_read_last_page,
    .tbl_dest, .rom_word, .tbl_addr, .tbl_rom_rd, .tbl_busy, .alu_go, .alu_op, .alu_a,
    .alu_b, .alu_cin, .alu_result, .op_watchdog_kick, .op_sleep, .wdt_timeout,
    .alu_flag_register
  );

  // Small variant on the same bus: seven-bit pointer and its own data range
  css_core_state #(.LARGE(1'b0)) dut_small (
    .clk_sys, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(rdata_s), .pc_now,
    .op_call, .op_subroutine_exit, .op_interrupt_exit, .int_pending, .int_ack(), .pc_restore(),
    .pc_restore_valid(), .stack_full(), .op_table_read_current_page, .op_table_read_last_page,
    .tbl_dest, .rom_word, .tbl_addr(), .tbl_rom_rd(), .tbl_busy(), .alu_go, .alu_op, .alu_a,
    .alu_b, .alu_cin, .alu_result(), .op_watchdog_kick, .op_sleep, .wdt_timeout,
    .alu_flag_register()
  );

  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  // ----------------------------------------------------------------------
  // Bus and strobe tasks
  // ----------------------------------------------------------------------
  task automatic results();
    if (err_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // One-cycle write; returns just after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] dv);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= dv;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read; data stand only in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  // One-cycle pulse on one strobe; a gap cycle always separates two pulses
  task automatic ev(input int k);
    @(posedge clk_sys);
    case (k)
      0: wdt_timeout <= 1'b1;
      1: op_sleep <= 1'b1;
      2: op_watchdog_kick <= 1'b1;
      3: op_call <= 1'b1;
      4: op_subroutine_exit <= 1'b1;
      5: op_interrupt_exit <= 1'b1;
      6: op_table_read_current_page <= 1'b1;
      7: op_table_read_last_page <= 1'b1;
      default: alu_go <= 1'b1;
    endcase
    @(posedge clk_sys);
    {wdt_timeout, op_sleep, op_watchdog_kick, op_call, op_subroutine_exit, op_interrupt_exit,
     op_table_read_current_page, op_table_read_last_page, alu_go} <= '0;
    #1;
  endtask : ev

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(5247));
    {arst_n, reg_wr, reg_rd, int_pending, op_call, op_subroutine_exit, op_interrupt_exit} = '0;
    {op_table_read_current_page, op_table_read_last_page, alu_go, alu_cin} = '0;
    {op_watchdog_kick, op_sleep, wdt_timeout} = '0;
    {reg_addr, reg_wdata, tbl_dest, alu_a, alu_b, pc_now, rom_word} = '0;
    alu_op = CSS_ALU_ADD;
    mf = `CSS_FLAGS_RESET;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    tick();
    `CHK("reset flags", mf, alu_flag_register)
    `CHK("reset full", 1'b0, stack_full)
    // Indirect access through the pointer, including both ends of general memory
    for (i = 0; i < 4; i++) begin
      p = (i == 0) ? `CSS_GP_LO_LARGE : (i == 1) ? `CSS_GP_HI_LARGE : 8'(8'h40 + $urandom_range(191));
      d = 8'($urandom);
      wr(`CSS_ADDR_POINTER, p);
      wr(`CSS_ADDR_INDIRECT, d);
      rd(p);
      `CHK("indirect write", d, rv)
      wr(p, ~d);
      rd(`CSS_ADDR_INDIRECT);
      `CHK("indirect read", ~d, rv)
      rd(`CSS_ADDR_POINTER);
      `CHK("pointer", p, rv)
      `CHK("small pointer", {1'b1, p[6:0]}, rdata_s)
    end
    wr(`CSS_ADDR_POINTER, 8'h00);
    wr(`CSS_ADDR_INDIRECT, 8'h5a);
    rd(`CSS_ADDR_INDIRECT);
    `CHK("pointer zero", 8'h00, rv)
    rd(8'h3f);
    `CHK("reserved", 8'h00, rv)
    rd(8'h27);
    `CHK("reserved edge", 8'h00, rv)
    `CHK("small reserved edge", 8'h00, rdata_s)
    // Software writes reach only the four arithmetic flags
    wr(`CSS_ADDR_FLAGS, 8'hff);
    mf = 8'h0f;
    `CHK("flag write", mf, alu_flag_register)
    ev(0);
    mf[5] = 1'b1;
    `CHK("timeout", mf, alu_flag_register)
    ev(1);
    mf[5:4] = 2'b01;
    `CHK("sleep", mf, alu_flag_register)
    wr(`CSS_ADDR_FLAGS, 8'he0);
    mf = 8'h10;
    rd(`CSS_ADDR_FLAGS);
    `CHK("flag keep", mf, rv)
    ev(0);
    ev(2);
    mf[5:4] = 2'b00;
    `CHK("kick", mf, alu_flag_register)
    // Every ALU class, rotates fed with the current carry
    for (i = 0; i < 42; i++) begin
      @(posedge clk_sys);
      alu_op  <= css_alu_op_t'(i % 7);
      alu_a   <= 8'($urandom);
      alu_b   <= 8'($urandom);
      alu_cin <= (i % 7 > 4) ? mf[0] : 1'($urandom);
      ev(8);
      b2 = (alu_op == CSS_ALU_SUB) ? ~alu_b : alu_b;
      s = 9'(alu_a) + 9'(b2) + 9'(alu_cin);
      case (alu_op)
        CSS_ALU_ADD, CSS_ALU_SUB: begin
          r = s[7:0];
          h = alu_a[3:0] + b2[3:0] + alu_cin;
          mf[1] = (h > 15);
          h = alu_a[6:0] + b2[6:0] + alu_cin;
          mf[3] = s[8] ^ (h > 127);
          mf[0] = s[8];
        end
        CSS_ALU_AND: r = alu_a & alu_b;
        CSS_ALU_OR:  r = alu_a | alu_b;
        CSS_ALU_XOR: r = alu_a ^ alu_b;
        CSS_ALU_RLC: r = {alu_a[6:0], alu_cin};
        default:     r = {alu_cin, alu_a[7:1]};
      endcase
      if (i % 7 < 5) mf[2] = (r == 8'h00);
      if (i % 7 > 4) mf[0] = (i % 7 == 5) ? alu_a[7] : alu_a[0];
      `CHK("alu result", r, alu_result)
      `CHK("alu flags", mf, alu_flag_register)
    end
    // Table reads on the current page and the last page
    for (i = 0; i < 2; i++) begin
      p = 8'($urandom);
      rw = 15'($urandom);
      wr(`CSS_ADDR_TBL_PTR, p);
      @(posedge clk_sys);
      pc_now   <= 12'($urandom);
      tbl_dest <= 8'h50;
      rom_word <= rw;
      ev(6 + i);
      `CHK("table addr", {(i == 1) ? `CSS_LAST_PAGE : pc_now[11:8], p}, tbl_addr)
      `CHK("rom read", 1'b1, tbl_rom_rd)
      tick();
      `CHK("busy second", 1'b1, tbl_busy)
      tick();
      `CHK("busy done", 1'b0, tbl_busy)
      rd(8'h50);
      `CHK("table low", rw[7:0], rv)
      rd(`CSS_ADDR_TBL_HIGH);
      `CHK("table high", {1'b0, rw[14:8]}, rv)
    end
    // Seven calls: the oldest address is lost, then a held interrupt
    for (i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      e12 = 12'($urandom);
      pc_now <= e12;
      q.push_back(e12);
      if (q.size() > 6) void'(q.pop_front());
      ev(3);
    end
    `CHK("full", 1'b1, stack_full)
    @(posedge clk_sys);
    pc_now      <= 12'h3c0;
    int_pending <= 1'b1;
    for (i = 0; i < 5; i++) begin
      tick();
      `CHK("ack held", 1'b0, int_ack)
    end
    ev(4);
    e12 = q.pop_back();
    `CHK("pop", e12, pc_restore)
    for (i = 0; i < 5 && int_ack !== 1'b1; i++) tick();
    `CHK("ack", 1'b1, int_ack)
    q.push_back(12'h3c0);
    @(posedge clk_sys);
    int_pending <= 1'b0;
    for (i = 0; i < 6; i++) begin
      ev(4 + i % 2);
      e12 = q.pop_back();
      `CHK("restore", e12, pc_restore)
      `CHK("restore valid", 1'b1, pc_restore_valid)
    end
    `CHK("not full", 1'b0, stack_full)
    results();
  end
endmodule : css_core_state_tb

// ===== css_pkg.sv
// Types shared by the core state block.
// Assumes css_regs.svh carries the numeric constants.
package css_pkg;

  // ALU operation classes that drive flag updates
  typedef enum logic [2:0] {
    CSS_ALU_ADD = 3'b000,
    CSS_ALU_SUB = 3'b001,
    CSS_ALU_AND = 3'b010,
    CSS_ALU_OR  = 3'b011,
    CSS_ALU_XOR = 3'b100,
    CSS_ALU_RLC = 3'b101,
    CSS_ALU_RRC = 3'b110
  } css_alu_op_t;

  // Table read sequence
  typedef enum logic [1:0] {
    CSS_TB_IDLE  = 2'b00,
    CSS_TB_FETCH = 2'b01,
    CSS_TB_STORE = 2'b10
  } css_tbl_state_t;

endpackage : css_pkg

// ===== css_regs.svh
// Constants for the core state block: data map, flag bits, stack, table timing.
// Assumes an 8-bit data space and a program space of at most 12 address bits.
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

// ----------------------------------------------------------------------------
// Data memory map
// ----------------------------------------------------------------------------
`define CSS_ADDR_INDIRECT   8'h00
`define CSS_ADDR_POINTER    8'h01
`define CSS_ADDR_TBL_PTR    8'h07
`define CSS_ADDR_TBL_HIGH   8'h08
`define CSS_ADDR_FLAGS      8'h0a
`define CSS_GP_LO_SMALL     8'h28
`define CSS_GP_HI_SMALL     8'h7f
`define CSS_GP_LO_LARGE     8'h40
`define CSS_GP_HI_LARGE     8'hff

// ----------------------------------------------------------------------------
// Flag register fields and reset values
// ----------------------------------------------------------------------------
`define CSS_FLAG_C          0
`define CSS_FLAG_AC         1
`define CSS_FLAG_Z          2
`define CSS_FLAG_OV         3
`define CSS_FLAG_SLEEP      4
`define CSS_FLAG_WDOG       5
`define CSS_FLAGS_RESET     8'h00
`define CSS_FLAGS_SW_MASK   8'h0f
`define CSS_PTR_RESET       8'h00

// ----------------------------------------------------------------------------
// Stack and table timing
// ----------------------------------------------------------------------------
`define CSS_STACK_DEPTH     3'h6
`define CSS_TABLE_CYCLES    2
`define CSS_LAST_PAGE       4'hf

`endif
